// ===== common/iox_consts.svh
`ifndef IOX_CONSTS_SVH
`define IOX_CONSTS_SVH

// Port geometry
`define IOX_WIDTH_WORD   16'h0010
`define IOX_MASK_WORD    16'hFFFF

// Reset values: every pin an input, latches cleared
`define IOX_DIR_RST      16'hFFFF
`define IOX_LAT_RST      16'h0000

// Expander address, 8-bit form; bit 0 becomes R/W
`define IOX_DEF_ADDR     8'h48

// Expander register pointers, low then high
`define IOX_REG_DIR      8'h00
`define IOX_REG_PIN      8'h02
`define IOX_REG_LAT      8'h04

// Quarter bit time in core cycles
`define IOX_QUARTER_CYC  250

// Script steps
`define IOX_STEP_LO_RD   4'hB
`define IOX_STEP_HI_RD   4'hC

`endif

// ===== common/iox_i2c_if.sv
`timescale 1ns/100ps
interface iox_i2c_if;
    import iox_pkg::*;

    logic         cmd_valid;    // Sequencer offers a command
    iox_i2c_cmd_e cmd;          // Command kind
    logic [7:0]   tx_byte;      // Byte to send
    logic         rx_nack;      // Answer with nack after a read byte
    logic         cmd_ready;    // Engine idle
    logic         done;         // Command finished, one cycle
    logic [7:0]   rx_byte;      // Byte received
    logic         ack_missing;  // Target did not acknowledge

    modport ctrl (output cmd_valid, cmd, tx_byte, rx_nack,
                  input  cmd_ready, done, rx_byte, ack_missing);
    modport engine (input  cmd_valid, cmd, tx_byte, rx_nack,
                    output cmd_ready, done, rx_byte, ack_missing);
endinterface

// ===== common/iox_pkg.sv
package iox_pkg;

    // Host property operations
    typedef enum logic [3:0] {
        IOX_OP_WIDTH      = 4'h0,
        IOX_OP_MASK       = 4'h1,
        IOX_OP_SINGLE_PIN = 4'h2,
        IOX_OP_LATCH      = 4'h3,
        IOX_OP_LATCH_BIT  = 4'h4,
        IOX_OP_PINS       = 4'h5,
        IOX_OP_PINS_BIT   = 4'h6,
        IOX_OP_DATA       = 4'h7,
        IOX_OP_DATA_BIT   = 4'h8,
        IOX_OP_DIR        = 4'h9,
        IOX_OP_DIR_BIT    = 4'hA,
        IOX_OP_LANE       = 4'hB
    } iox_op_e;

    // Byte-level two-wire commands
    typedef enum logic [1:0] {
        IOX_I2C_START = 2'h0,
        IOX_I2C_STOP  = 2'h1,
        IOX_I2C_WRITE = 2'h2,
        IOX_I2C_READ  = 2'h3
    } iox_i2c_cmd_e;

    // Sequencer states
    typedef enum logic [1:0] {
        IOX_ST_IDLE = 2'h0,
        IOX_ST_RUN  = 2'h1,
        IOX_ST_WAIT = 2'h2,
        IOX_ST_RESP = 2'h3
    } iox_state_e;

    // One script step
    typedef struct packed {
        iox_i2c_cmd_e cmd;
        logic [7:0]   data;
        logic         last;
    } iox_step_s;

endpackage

// ===== hdl/iox_i2c_engine.sv
`timescale 1ns/100ps
`include "iox_consts.svh"
module iox_i2c_engine #(
    parameter int QUARTER_CYC = `IOX_QUARTER_CYC
) (
    input  wire logic  core_clk,  // Core clock
    input  wire logic  reset,     // Synchronous reset
    iox_i2c_if.engine  bus,       // Command side
    output logic       scl_out,   // Clock line level when driven
    output logic       scl_oe,    // Clock line pulled low
    input  wire logic  sda_in,    // Data line as seen on the pin
    output logic       sda_out,   // Data line level when driven
    output logic       sda_oe     // Data line pulled low
);
    import iox_pkg::*;

    localparam logic [15:0] TQ = 16'(QUARTER_CYC - 1);

    logic         sda_meta;
    logic         sda_sync;
    logic         active;
    iox_i2c_cmd_e cmd_q;
    logic [1:0]   phase;
    logic [3:0]   bitn;
    logic [15:0]  timer;
    logic [8:0]   shift;
    logic [8:0]   rx;
    logic         tick;
    logic         is_bit;

    // Line levels per phase; 1 means released
    function automatic logic [1:0] line_lvl(input iox_i2c_cmd_e c, input logic [1:0] p, input logic b);
        logic [1:0] l;
        l = 2'b11;
        unique case (c)
            IOX_I2C_START: l = {(p == 2'd1) || (p == 2'd2), p < 2'd2};
            IOX_I2C_STOP:  l = {p != 2'd0, p >= 2'd2};
            IOX_I2C_WRITE,
            IOX_I2C_READ:  l = {(p == 2'd1) || (p == 2'd2), b};
        endcase
        return l;
    endfunction

    assign tick          = active && (timer == TQ);
    assign is_bit        = (cmd_q == IOX_I2C_WRITE) || (cmd_q == IOX_I2C_READ);
    assign bus.cmd_ready = !active;
    // Open drain: only ever pull low
    assign scl_out       = 1'b0;
    assign sda_out       = 1'b0;

    // Pin synchroniser
    always_ff @(posedge core_clk) begin
        sda_meta <= sda_in;
        sda_sync <= sda_meta;
    end

    // Quarter bit timer
    always_ff @(posedge core_clk) begin
        if (reset || !active || tick) begin
            timer <= 16'h0000;
        end else begin
            timer <= timer + 16'h0001;
        end
    end

    // Command and bit sequencing
    always_ff @(posedge core_clk) begin
        if (reset) begin
            active          <= 1'b0;
            cmd_q           <= IOX_I2C_START;
            phase           <= 2'd0;
            bitn            <= 4'h0;
            shift           <= 9'h1FF;
            rx              <= 9'h000;
            bus.done        <= 1'b0;
            bus.rx_byte     <= 8'h00;
            bus.ack_missing <= 1'b0;
        end else begin
            bus.done <= 1'b0;
            if (!active) begin
                if (bus.cmd_valid) begin
                    active <= 1'b1;
                    cmd_q  <= bus.cmd;
                    phase  <= 2'd0;
                    bitn   <= 4'h0;
                    // Read bytes release the line, ninth bit carries our answer
                    shift  <= (bus.cmd == IOX_I2C_READ) ? {8'hFF, bus.rx_nack} : {bus.tx_byte, 1'b1};
                end
            end else if (tick) begin
                if (phase == 2'd2) begin
                    rx <= {rx[7:0], sda_sync};
                end
                phase <= phase + 2'd1;
                if (phase == 2'd3) begin
                    if (is_bit && bitn != 4'h8) begin
                        bitn  <= bitn + 4'h1;
                        shift <= {shift[7:0], 1'b1};
                    end else begin
                        active          <= 1'b0;
                        bus.done        <= 1'b1;
                        bus.rx_byte     <= rx[8:1];
                        bus.ack_missing <= rx[0];
                    end
                end
            end
        end
    end

    // Line drivers; hold between commands so clock stays low mid-frame
    always_ff @(posedge core_clk) begin
        if (reset) begin
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
        end else if (active) begin
            {scl_oe, sda_oe} <= ~line_lvl(cmd_q, phase, shift[8]);
        end
    end
endmodule

// ===== hdl/iox_port.sv
`timescale 1ns/100ps
`include "iox_consts.svh"
// Notes on behaviour
// RL1: Expander reached at configurable address, default 0x48
// RL2: Low byte port one, high byte port two
// RL3: Width property reads sixteen
// RL4: Mask property reads FFFF
// RL5: Single pin write: that pin output, latch loaded
// RL6: Single pin read: that pin input, level returned
// RL7: Whole latch write: all outputs, latches loaded
// RL8: Whole latch read returns latches, direction kept
// RL9: Indexed latch write: pin output, bit loaded
// RL10: Indexed latch read returns bit, direction kept
// RL11: Whole pin read: all inputs, levels returned
// RL12: Indexed pin read: that pin input, level
// RL13: Whole combined access: latch write, pin read
// RL14: Indexed combined access: latch write, pin read
// RL15: Whole direction read: one means input
// RL16: Indexed direction read: one means input
// RL17: Lane zero pins 0-7, lane one 8-15
// RL18: Lane write: lane outputs, other lane untouched
// RL19: Bit k of whole values is pin k
module iox_port #(
    parameter logic [7:0] TARGET_ADDR = `IOX_DEF_ADDR,     // Default expander address
    parameter int         QUARTER_CYC = `IOX_QUARTER_CYC   // Quarter bit time in cycles
) (
    input  wire logic           core_clk,      // Core clock
    input  wire logic           reset,         // Synchronous reset
    input  wire logic           addr_opt_en,   // Use addr_opt instead of default
    input  wire logic [7:0]     addr_opt,      // Address option
    input  wire logic           req_valid,     // Property access offered
    output logic                req_ready,     // Access taken this cycle
    input  wire logic           req_write,     // 1 write, 0 read
    input  iox_pkg::iox_op_e    req_op,        // Which property
    input  wire logic [3:0]     req_index,     // Pin or lane index
    input  wire logic [15:0]    req_wdata,     // Write value
    output logic                resp_valid,    // Answer, one cycle
    output logic [15:0]         resp_data,     // Read value
    output logic                resp_error,    // Refused write or no ack
    output logic                busy,          // Expander transfer running
    output logic [15:0]         pin_dir,       // Direction, 1 is input
    output logic [15:0]         pin_latch,     // Output latches
    output logic [15:0]         pin_levels,    // Last sampled levels
    output logic                scl_out,       // Clock line drive level
    output logic                scl_oe,        // Clock line pulled low
    input  wire logic           sda_in,        // Data line pin
    output logic                sda_out,       // Data line drive level
    output logic                sda_oe         // Data line pulled low
);
    import iox_pkg::*;

    iox_i2c_if i2c();

    iox_state_e  state;
    logic        take;
    logic        is_pin_rd;
    logic        is_out_wr;
    logic        is_whole;
    logic [15:0] sel;
    logic [15:0] lane_sel;
    logic [15:0] lane_word;
    logic [15:0] local_rd;
    logic [15:0] dir;
    logic [15:0] lat;
    logic [15:0] pins;
    logic        job_rd;
    logic        job_whole;
    logic [3:0]  job_idx;
    logic [7:0]  job_addr;
    logic        job_err;
    logic [3:0]  step_idx;
    iox_step_s   cur;

    // Two-wire script: latches before direction, so a pin never drives a stale level
    function automatic iox_step_s step_of(input logic rd, input logic [3:0] n, input logic [7:0] a,
                                          input logic [15:0] d, input logic [15:0] l);
        iox_step_s s;
        s = '{cmd: IOX_I2C_WRITE, data: 8'h00, last: 1'b0};
        if (!rd) begin
            case (n)
                4'h0, 4'h6: s.cmd = IOX_I2C_START;
                4'h1, 4'h7: s.data = {a[7:1], 1'b0};  // RL1
                4'h2:       s.data = `IOX_REG_LAT;
                4'h3:       s.data = l[7:0];           // RL2
                4'h4:       s.data = l[15:8];          // RL2
                4'h5:       s.cmd = IOX_I2C_STOP;
                4'h8:       s.data = `IOX_REG_DIR;
                4'h9:       s.data = d[7:0];
                4'hA:       s.data = d[15:8];
                default: begin
                    s.cmd  = IOX_I2C_STOP;
                    s.last = 1'b1;
                end
            endcase
        end else begin
            // Direction goes out first, then the pins are sampled
            case (n)
                4'h0, 4'h6, 4'h9: s.cmd = IOX_I2C_START;
                4'h1, 4'h7:       s.data = {a[7:1], 1'b0};
                4'h2:             s.data = `IOX_REG_DIR;
                4'h3:             s.data = d[7:0];
                4'h4:             s.data = d[15:8];
                4'h5:             s.cmd = IOX_I2C_STOP;
                4'h8:             s.data = `IOX_REG_PIN;
                4'hA:             s.data = {a[7:1], 1'b1};  // RL1
                `IOX_STEP_LO_RD:  s.cmd = IOX_I2C_READ;
                `IOX_STEP_HI_RD: begin
                    s.cmd  = IOX_I2C_READ;
                    s.data = 8'h01;  // Nack ends the read
                end
                default: begin
                    s.cmd  = IOX_I2C_STOP;
                    s.last = 1'b1;
                end
            endcase
        end
        return s;
    endfunction

    // Classify the offered access
    always_comb begin
        is_pin_rd = !req_write && (req_op inside {IOX_OP_PINS, IOX_OP_PINS_BIT, IOX_OP_DATA,
                                                  IOX_OP_DATA_BIT, IOX_OP_SINGLE_PIN});
        is_out_wr = req_write && (req_op inside {IOX_OP_LATCH, IOX_OP_LATCH_BIT, IOX_OP_DATA,
                                                 IOX_OP_DATA_BIT, IOX_OP_SINGLE_PIN, IOX_OP_LANE});
        is_whole  = req_op inside {IOX_OP_LATCH, IOX_OP_PINS, IOX_OP_DATA, IOX_OP_DIR};
    end

    // Selects for pin and lane
    assign sel       = 16'h0001 << req_index;
    assign lane_sel  = req_index[0] ? 16'hFF00 : 16'h00FF;        // RL17
    assign lane_word = {req_wdata[7:0], req_wdata[7:0]} & lane_sel;

    // Answers that need no expander transfer
    always_comb begin
        case (req_op)
            IOX_OP_WIDTH:     local_rd = `IOX_WIDTH_WORD;          // RL3
            IOX_OP_MASK:      local_rd = `IOX_MASK_WORD;           // RL4
            IOX_OP_LATCH:     local_rd = lat;                      // RL8
            IOX_OP_LATCH_BIT: local_rd = {15'h0000, lat[req_index]};  // RL10
            IOX_OP_DIR:       local_rd = dir;                      // RL15
            IOX_OP_DIR_BIT:   local_rd = {15'h0000, dir[req_index]};  // RL16
            IOX_OP_LANE:      local_rd = req_index[0] ? {8'h00, lat[15:8]} : {8'h00, lat[7:0]};
            default:          local_rd = 16'h0000;
        endcase
    end

    // Only one access in flight; local reads answer in one cycle
    assign req_ready = (state == IOX_ST_IDLE);
    assign take      = req_valid && req_ready;
    assign busy      = (state != IOX_ST_IDLE);
    assign pin_dir   = dir;
    assign pin_latch = lat;

    // Direction shadow, 1 is input
    always_ff @(posedge core_clk) begin
        if (reset) begin
            dir <= `IOX_DIR_RST;
        end else if (take && is_out_wr) begin
            if (req_op == IOX_OP_LANE) begin
                dir <= dir & ~lane_sel;  // RL18
            end else if (is_whole) begin
                dir <= 16'h0000;         // RL7 RL13
            end else begin
                dir <= dir & ~sel;       // RL5 RL9 RL14
            end
        end else if (take && is_pin_rd) begin
            if (is_whole) begin
                dir <= 16'hFFFF;         // RL11 RL13
            end else begin
                dir <= dir | sel;        // RL6 RL12 RL14
            end
        end
    end

    // Output latches
    always_ff @(posedge core_clk) begin
        if (reset) begin
            lat <= `IOX_LAT_RST;
        end else if (take && is_out_wr) begin
            if (req_op == IOX_OP_LANE) begin
                lat <= (lat & ~lane_sel) | lane_word;              // RL17 RL18
            end else if (is_whole) begin
                lat <= req_wdata;                                  // RL7 RL19
            end else begin
                lat <= (lat & ~sel) | (req_wdata[0] ? sel : 16'h0000);  // RL5 RL9
            end
        end
    end

    // Job context held for the whole transfer
    always_ff @(posedge core_clk) begin
        if (reset) begin
            job_rd    <= 1'b0;
            job_whole <= 1'b0;
            job_idx   <= 4'h0;
            job_addr  <= TARGET_ADDR;
        end else if (take) begin
            job_rd    <= is_pin_rd;
            job_whole <= is_whole;
            job_idx   <= req_index;
            job_addr  <= addr_opt_en ? addr_opt : TARGET_ADDR;  // RL1
        end
    end

    // Script step and command offer
    assign cur           = step_of(job_rd, step_idx, job_addr, dir, lat);
    assign i2c.cmd_valid = (state == IOX_ST_RUN);
    assign i2c.cmd       = cur.cmd;
    assign i2c.tx_byte   = cur.data;
    assign i2c.rx_nack   = cur.data[0];

    // Sequencer
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state <= IOX_ST_IDLE;
        end else begin
            unique case (state)
                IOX_ST_IDLE: begin
                    if (take && (is_pin_rd || is_out_wr)) begin
                        state <= IOX_ST_RUN;
                    end
                end
                IOX_ST_RUN: begin
                    if (i2c.cmd_ready) begin
                        state <= IOX_ST_WAIT;
                    end
                end
                IOX_ST_WAIT: begin
                    if (i2c.done) begin
                        state <= cur.last ? IOX_ST_RESP : IOX_ST_RUN;
                    end
                end
                IOX_ST_RESP: state <= IOX_ST_IDLE;
            endcase
        end
    end

    // Step counter
    always_ff @(posedge core_clk) begin
        if (reset || take) begin
            step_idx <= 4'h0;
        end else if (state == IOX_ST_WAIT && i2c.done && !cur.last) begin
            step_idx <= step_idx + 4'h1;
        end
    end

    // Sampled pin levels, low byte first
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pins <= 16'h0000;
        end else if (state == IOX_ST_WAIT && i2c.done && cur.cmd == IOX_I2C_READ) begin
            if (step_idx == `IOX_STEP_LO_RD) begin
                pins[7:0] <= i2c.rx_byte;   // RL2
            end else begin
                pins[15:8] <= i2c.rx_byte;  // RL2
            end
        end
    end
    assign pin_levels = pins;

    // Missing acknowledge on any sent byte spoils the job
    always_ff @(posedge core_clk) begin
        if (reset || take) begin
            job_err <= 1'b0;
        end else if (state == IOX_ST_WAIT && i2c.done && cur.cmd == IOX_I2C_WRITE && i2c.ack_missing) begin
            job_err <= 1'b1;
        end
    end

    // Answer to the host
    always_ff @(posedge core_clk) begin
        if (reset) begin
            resp_valid <= 1'b0;
            resp_data  <= 16'h0000;
            resp_error <= 1'b0;
        end else begin
            resp_valid <= 1'b0;
            if (take && !is_pin_rd && !is_out_wr) begin
                // Writes to read-only properties change nothing
                resp_valid <= 1'b1;
                resp_data  <= req_write ? 16'h0000 : local_rd;
                resp_error <= req_write;
            end else if (state == IOX_ST_RESP) begin
                resp_valid <= 1'b1;
                resp_error <= job_err;
                if (!job_rd) begin
                    resp_data <= 16'h0000;
                end else if (job_whole) begin
                    resp_data <= pins;                     // RL11 RL19
                end else begin
                    resp_data <= {15'h0000, pins[job_idx]};  // RL6 RL12
                end
            end
        end
    end

    // Two-wire engine
    iox_i2c_engine #(
        .QUARTER_CYC (QUARTER_CYC)
    ) u_engine (
        .core_clk (core_clk),
        .reset    (reset),
        .bus      (i2c.engine),
        .scl_out  (scl_out),
        .scl_oe   (scl_oe),
        .sda_in   (sda_in),
        .sda_out  (sda_out),
        .sda_oe   (sda_oe)
    );
endmodule

// ===== tb/iox_expander_model.sv
`timescale 1ns/100ps
module iox_expander_model #(
    parameter logic [7:0] ADDR = 8'h48  // Address it answers to
) (
    input  wire logic        scl,       // Clock line
    input  wire logic        sda,       // Data line
    output logic             sda_pull,  // Pulls data low
    input  wire logic [15:0] ext_pins,  // Pin levels
    output logic [15:0]      dir_seen,  // Direction pair 00/01
    output logic [15:0]      lat_seen   // Latch pair 04/05
);
    logic [7:0] regs [0:7] = '{default: 8'h00};
    logic [7:0] ptr = 8'h00;
    logic [7:0] sh = 8'h00;
    logic [7:0] tx = 8'hFF;
    logic       sel = 1'b0;
    logic       rd = 1'b0;
    logic       fresh = 1'b0;
    int         bitn = 0;
    initial sda_pull = 1'b0;
    assign dir_seen = {regs[1], regs[0]};
    assign lat_seen = {regs[5], regs[4]};
    int         byten = 0;
    // Start and stop; fresh skips the clock fall that ends a start
    always @(negedge sda) begin
        if (scl === 1'b1) begin
            bitn = 0;
            byten = 0;
            sel = 1'b0;
            rd = 1'b0;
            fresh = 1'b1;
        end
    end
    always @(posedge sda) begin
        if (scl === 1'b1) begin
            sel = 1'b0;
            sda_pull = 1'b0;
        end
    end
    // Sample bits; a nack from the host ends a read
    always @(posedge scl) begin
        if (bitn < 8) begin
            sh = {sh[6:0], sda};
        end else if (rd && sda === 1'b1) begin
            sel = 1'b0;
        end
    end
    // Drive only while the clock is low
    always @(negedge scl) begin
        if (fresh) begin
            fresh = 1'b0;
        end else if (bitn == 8) begin
            bitn = 0;
            byten++;
            sda_pull = 1'b0;
            if (sel && rd) begin
                tx = (ptr == 8'h02) ? ext_pins[7:0] : (ptr == 8'h03) ? ext_pins[15:8] : regs[ptr[2:0]];
                ptr++;
                sda_pull = !tx[7];
            end
        end else begin
            bitn++;
            if (bitn == 8 && !rd) begin
                if (byten == 0) begin
                    sel = (sh[7:1] == ADDR[7:1]);
                    rd = sh[0];
                end else if (byten == 1 && sel) begin
                    ptr = sh;
                end else if (sel) begin
                    regs[ptr[2:0]] = sh;
                    ptr++;
                end
                sda_pull = sel;
            end else begin
                sda_pull = rd && sel && bitn < 8 && !tx[7 - bitn];
            end
        end
    end
endmodule

// ===== tb/iox_port_assertions.sv
`timescale 1ns/100ps
module iox_port_assertions
    import iox_pkg::*;
(
    input wire logic        core_clk,   // Core clock
    input wire logic        reset,      // Synchronous reset
    input wire logic        req_valid,  // Offer
    input wire logic        req_ready,  // Accept
    input wire logic        req_write,  // Write flag
    input iox_pkg::iox_op_e req_op,     // Property
    input wire logic [3:0]  req_index,  // Pin or lane
    input wire logic [15:0] req_wdata,  // Write value
    input wire logic        resp_valid, // Answer
    input wire logic [15:0] resp_data,  // Read value
    input wire logic [15:0] pin_dir,    // Direction
    input wire logic [15:0] pin_latch   // Latches
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    // Accepted reads and writes
    wire logic rd = req_valid && req_ready && !req_write;
    wire logic wr = req_valid && req_ready && req_write;

    width_read_a: assert property (rd && req_op == IOX_OP_WIDTH |=> resp_valid && resp_data == 16'h0010)
        else $error("width");
    latch_write_a: assert property (wr && req_op == IOX_OP_LATCH |=>
        pin_dir == 16'h0000 && pin_latch == $past(req_wdata)) else $error("latch write");
    latch_read_a: assert property (rd && req_op == IOX_OP_LATCH |=>
        resp_valid && resp_data == $past(pin_latch) && $stable(pin_dir)) else $error("latch read");
    pins_read_a: assert property (rd && req_op == IOX_OP_PINS |=> pin_dir == 16'hFFFF)
        else $error("pin read");
    bit_read_a: assert property (rd && req_op == IOX_OP_PINS_BIT |=>
        pin_dir == ($past(pin_dir) | (16'h0001 << $past(req_index)))) else $error("bit read");
    single_write_a: assert property (wr && req_op == IOX_OP_SINGLE_PIN |=>
        pin_dir == ($past(pin_dir) & ~(16'h0001 << $past(req_index)))
        && pin_latch[$past(req_index)] == $past(req_wdata[0])) else $error("pin write");
    dir_read_a: assert property (rd && req_op == IOX_OP_DIR |=> resp_valid && resp_data == $past(pin_dir))
        else $error("dir read");
    lane_write_a: assert property (wr && req_op == IOX_OP_LANE && !req_index[0] |=>
        pin_dir[7:0] == 8'h00 && $stable(pin_dir[15:8]) && pin_latch[7:0] == $past(req_wdata[7:0]))
        else $error("lane write");
endmodule

bind iox_port iox_port_assertions chk_i (.core_clk(core_clk), .reset(reset), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_op(req_op), .req_index(req_index),
    .req_wdata(req_wdata), .resp_valid(resp_valid), .resp_data(resp_data), .pin_dir(pin_dir),
    .pin_latch(pin_latch));

// ===== tb/tb.sv
`timescale 1ns/100ps
module tb;
    import iox_pkg::*;
    logic        core_clk = 1'b0;
    logic        reset = 1'b1;
    logic        aen = 1'b0;
    logic [7:0]  aopt = 8'h00;
    logic        rv = 1'b0;
    logic        rw = 1'b0;
    iox_op_e     op_r = IOX_OP_WIDTH;
    logic [3:0]  idx_r = 4'h0;
    logic [15:0] wd_r = 16'h0000;
    logic [15:0] ext = 16'hA5C3;
    logic        ready, rvalid, rerror, busy, scl_oe, sda_oe, pull;
    logic [15:0] rdat, pdir, plat, plev, dseen, lseen;
    int          n_fail = 0;
    int          check_count = 0;
    wire logic   scl = !scl_oe; // Pull-ups on both lines
    wire logic   sda = !(sda_oe || pull);

    iox_port #(.QUARTER_CYC(2)) dut (.core_clk(core_clk), .reset(reset),
        .addr_opt_en(aen), .addr_opt(aopt), .req_valid(rv), .req_ready(ready), .req_write(rw),
        .req_op(op_r), .req_index(idx_r), .req_wdata(wd_r), .resp_valid(rvalid), .resp_data(rdat),
        .resp_error(rerror), .busy(busy), .pin_dir(pdir), .pin_latch(plat), .pin_levels(plev),
        .scl_out(), .scl_oe(scl_oe), .sda_in(sda), .sda_out(), .sda_oe(sda_oe));
    iox_expander_model far (.scl(scl), .sda(sda), .sda_pull(pull), .ext_pins(ext),
        .dir_seen(dseen), .lat_seen(lseen));

    always #5 core_clk = !core_clk;

    task automatic end_of_test();
        if (n_fail == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Hold request until taken, then await answer
    task automatic acc(input logic wr, input iox_op_e op, input logic [3:0] ix, input logic [15:0] wd);
        int n;
        rv <= 1'b1;
        rw <= wr;
        op_r <= op;
        idx_r <= ix;
        wd_r <= wd;
        n = 0;
        do begin @(negedge core_clk); n++; end while (ready !== 1'b1 && n < 9000);
        @(posedge core_clk);
        rv <= 1'b0;
        do begin @(negedge core_clk); n++; end while (rvalid !== 1'b1 && n < 9000);
        if (n >= 9000) begin n_fail++; end_of_test(); end
        @(posedge core_clk);
    endtask

    initial begin
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        acc(0, IOX_OP_WIDTH, 0, 0); chk(rdat, 16'h0010);
        acc(0, IOX_OP_MASK, 0, 0); chk(rdat, 16'hFFFF);
        acc(0, IOX_OP_DIR, 0, 0); chk(rdat, 16'hFFFF);
        acc(1, IOX_OP_DATA, 0, 16'h1234); chk(plat, 16'h1234);
        chk(pdir, 16'h0000);
        chk(16'(busy), 16'h0000);
        chk(lseen, 16'h1234);
        chk(dseen, 16'h0000);
        acc(0, IOX_OP_LATCH, 0, 0); chk(rdat, 16'h1234);
        acc(0, IOX_OP_LATCH_BIT, 4, 0); chk(rdat, 16'h0001);
        chk(pdir, 16'h0000);
        acc(0, IOX_OP_PINS_BIT, 8, 0); chk(rdat, 16'h0001);
        chk(pdir, 16'h0100);
        acc(0, IOX_OP_DIR_BIT, 8, 0); chk(rdat, 16'h0001);
        acc(0, IOX_OP_DIR_BIT, 7, 0); chk(rdat, 16'h0000);
        acc(0, IOX_OP_DATA, 0, 0); chk(rdat, 16'hA5C3);
        chk(plev, 16'hA5C3);
        acc(1, IOX_OP_LATCH, 0, 16'h0F0F); chk(lseen, 16'h0F0F);
        ext <= 16'h3C5A;
        acc(0, IOX_OP_PINS, 0, 0); chk(rdat, 16'h3C5A);
        chk(pdir, 16'hFFFF);
        acc(1, IOX_OP_SINGLE_PIN, 15, 1); chk(pdir, 16'h7FFF);
        chk(plat, 16'h8F0F);
        acc(0, IOX_OP_SINGLE_PIN, 15, 0); chk(rdat, 16'h0000);
        chk(pdir, 16'hFFFF);
        acc(1, IOX_OP_LATCH_BIT, 0, 0); chk(plat, 16'h8F0E);
        chk(pdir, 16'hFFFE);
        acc(1, IOX_OP_DATA_BIT, 1, 0); chk(plat, 16'h8F0C);
        acc(0, IOX_OP_DATA_BIT, 1, 0); chk(rdat, 16'h0001);
        chk(pdir, 16'hFFFE);
        acc(1, IOX_OP_LANE, 1, 16'h00AB); chk(plat, 16'hAB0C);
        chk(pdir, 16'h00FE);
        acc(1, IOX_OP_LANE, 0, 16'h0055); chk(lseen, 16'hAB55);
        chk(dseen, 16'h0000);
        acc(1, IOX_OP_WIDTH, 0, 16'h0001); chk(16'(rerror), 16'h0001);
        chk(plat, 16'hAB55);
        // Foreign address gets no ack
        aen <= 1'b1;
        aopt <= 8'h4A;
        acc(1, IOX_OP_DATA, 0, 16'hFFFF); chk(16'(rerror), 16'h0001);
        chk(lseen, 16'hAB55);
        aopt <= 8'h49;
        acc(1, IOX_OP_DATA, 0, 16'h0001); chk(16'(rerror), 16'h0000);
        chk(lseen, 16'h0001);
        end_of_test();
    end
endmodule
